// file: ddcm_cfg.svh
`ifndef DDCM_CFG_SVH
`define DDCM_CFG_SVH
// =============================================
// Register byte addresses
`define DDCM_ADDR_CTRL 12'h000
`define DDCM_ADDR_PTR 12'h004
`define DDCM_ADDR_XDAT 12'h008
`define DDCM_ADDR_WIN 12'h00C
`define DDCM_ADDR_SCTL 12'h010
`define DDCM_ADDR_SBYTE 12'h014
`define DDCM_ADDR_IRQ 12'h018
`define DDCM_ADDR_MASK 12'h01C
`define DDCM_ADDR_SLAVE 12'h020
// =============================================
// Control register bits; DDCM_B_I2CEN is a serial control register bit
`define DDCM_B_MODE 0
`define DDCM_B_SWF 1
`define DDCM_B_V1EN 2
`define DDCM_B_V1F 3
`define DDCM_B_WILD 4
`define DDCM_B_MAN 5
`define DDCM_B_SIZE 6
`define DDCM_B_RSV 7
`define DDCM_B_I2CEN 6
`define DDCM_CTRL_RST 8'h00
// =============================================
// Constants
`define DDCM_DDC2_ADDR 7'h50
`define DDCM_WILD_MASK 7'h7C
`define DDCM_VBIT_LAST 4'h8
`define DDCM_HALF_MASK 8'h7F
`define DDCM_BUF_DEPTH 256
`define DDCM_WIN_BASE 16'hFF00
`endif

// file: ddcm_pkg.sv
package ddcm_pkg;
    typedef enum logic [1:0] {DDCM_IDLE = 2'b00, DDCM_ADDR = 2'b01, DDCM_DATA = 2'b11} ddcm_bus_t;
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic active;
    } ddcm_aph_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ptr;
        logic [7:0] xdat;
        logic [7:0] sctl;
        logic [7:0] sbyte;
        logic [1:0] irqMask;
        ddcm_aph_t aph;
        logic [31:0] rdata;
        logic [2:0] vsSync;
        logic [3:0] vBitCnt;
        logic vsLast;
        logic [7:0] shiftOut;
        logic txBit;
        logic irq;
        logic engineRead;
        logic [7:0] engineByte;
        logic cpuSel;
        logic extSel;
        logic addrMatch;
    } ddcm_state_t;
endpackage

// file: ddc_slave_mode_control.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "ddcm_cfg.svh"
// Behaviour
// - Size bit clear selects a 128-byte buffer, set selects 256 bytes.
// - Manual mode clear: engine sends buffer bytes at the pointer location.
// - Manual mode set: interrupt each byte so software loads the next.
// - Wildcard clear matches A0/A1 only; set ignores two low address bits.
// - Vsync mode with manual mode sets its flag on the ninth vsync clock.
// - Vsync mode off ignores vsync but still serves serial requests.
// - Switching from vsync mode to serial mode sets the switch flag.
// - Mode bit reads 0 in vsync mode, 1 in serial mode, sticky until disabled.
// - Unit enabled when vsync enable or serial enable bit is set.
// - Disabled and automatic: no buffer access, window decodes externally.
// - Disabled and manual: processor reads and writes the buffer window.
// - Enabled and automatic: only engine uses buffer, processor blocked.
// - Enabled and manual: processor owns buffer, byte interrupt, serial byte held.
// - Pointer increments after every buffer window access.
// - Control register resets to zero.
module ddc_slave_mode_control
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hsel,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic vsyncClk,
    input wire logic serialAddrValid,
    input wire logic [6:0] serialAddr,
    input wire logic serialByteDone,
    input wire logic [7:0] serialByteIn,
    input wire logic [15:0] cpuDataAddr,
    output logic cpuBufSel,
    output logic cpuExtSel,
    output logic serialAddrMatch,
    output logic [7:0] engineByte,
    output logic engineRead,
    output logic sdaTxBit,
    output logic irq
);
    // =============================================
    // State
    ddcm_pkg::ddcm_state_t st, next_st;
    logic [7:0] mem [`DDCM_BUF_DEPTH];
    logic enabled;
    logic manual;
    logic bufLimit;
    logic winWr, winRd, engineFetch;
    logic vsRise;
    logic [7:0] ptrMasked;
    logic [7:0] ptrNext;
    logic [7:0] wb;
    logic [11:0] off;
    logic match;
    // =============================================
    // Decode helpers
    always_comb
    begin
        manual = st.ctrl[`DDCM_B_MAN];
        enabled = st.ctrl[`DDCM_B_V1EN] | st.sctl[`DDCM_B_I2CEN];
        bufLimit = st.ctrl[`DDCM_B_SIZE];
        ptrMasked = bufLimit ? st.ptr : (st.ptr & `DDCM_HALF_MASK);
        ptrNext = bufLimit ? (ptrMasked + 8'h01) : ((ptrMasked + 8'h01) & `DDCM_HALF_MASK);
        off = st.aph.addr[11:0];
        wb = hwdata[7:0];
        vsRise = st.vsSync[1] & ~st.vsSync[2];
        winWr = st.aph.active & st.aph.write & (off == `DDCM_ADDR_WIN) & manual;
        winRd = st.aph.active & ~st.aph.write & (off == `DDCM_ADDR_WIN) & manual;
        engineFetch = enabled & ~manual & st.ctrl[`DDCM_B_V1EN] & ~st.ctrl[`DDCM_B_MODE] & vsRise
            & (st.vBitCnt == `DDCM_VBIT_LAST);
        if (st.ctrl[`DDCM_B_WILD])
            match = (serialAddr & `DDCM_WILD_MASK) == (`DDCM_DDC2_ADDR & `DDCM_WILD_MASK);
        else
            match = serialAddr == `DDCM_DDC2_ADDR;
    end
    // =============================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.engineRead = 1'b0;
        next_st.vsSync = {st.vsSync[1:0], vsyncClk};
        // Bus address phase capture
        if (hready)
        begin
            next_st.aph.active = hsel & htrans[1];
            next_st.aph.addr = haddr;
            next_st.aph.write = hwrite;
        end
        // Register writes
        if (st.aph.active & st.aph.write)
        begin
            if (off == `DDCM_ADDR_CTRL)
            begin
                next_st.ctrl[`DDCM_B_SIZE] = wb[`DDCM_B_SIZE];
                next_st.ctrl[`DDCM_B_MAN] = wb[`DDCM_B_MAN];
                next_st.ctrl[`DDCM_B_WILD] = wb[`DDCM_B_WILD];
                next_st.ctrl[`DDCM_B_V1EN] = wb[`DDCM_B_V1EN];
                next_st.ctrl[`DDCM_B_V1F] = st.ctrl[`DDCM_B_V1F] & wb[`DDCM_B_V1F];
                next_st.ctrl[`DDCM_B_SWF] = st.ctrl[`DDCM_B_SWF] & wb[`DDCM_B_SWF];
            end
            else if (off == `DDCM_ADDR_PTR)
                next_st.ptr = wb;
            else if (off == `DDCM_ADDR_XDAT)
                next_st.xdat = wb;
            else if (off == `DDCM_ADDR_SCTL)
                next_st.sctl = wb;
            else if (off == `DDCM_ADDR_SBYTE)
                next_st.sbyte = wb;
            else if (off == `DDCM_ADDR_MASK)
                next_st.irqMask = hwdata[1:0];
        end
        next_st.ctrl[`DDCM_B_RSV] = 1'b0;
        // Pointer post increment
        if (winWr | winRd)
            next_st.ptr = ptrNext;
        // Vsync bit engine
        if (enabled & st.ctrl[`DDCM_B_V1EN] & ~st.ctrl[`DDCM_B_MODE] & vsRise)
        begin
            if (st.vBitCnt == `DDCM_VBIT_LAST)
            begin
                next_st.vBitCnt = 4'h0;
                next_st.txBit = 1'b1;
                if (manual)
                begin
                    next_st.shiftOut = st.xdat;
                    next_st.ctrl[`DDCM_B_V1F] = 1'b1;
                end
                else
                begin
                    next_st.shiftOut = mem[ptrMasked];
                    next_st.ptr = ptrNext;
                end
            end
            else
            begin
                next_st.vBitCnt = st.vBitCnt + 4'h1;
                next_st.txBit = st.shiftOut[7];
                next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
            end
        end
        // Serial mode entry
        if (enabled & serialAddrValid & match & st.sctl[`DDCM_B_I2CEN])
        begin
            if (~st.ctrl[`DDCM_B_MODE])
                next_st.ctrl[`DDCM_B_SWF] = 1'b1;
            next_st.ctrl[`DDCM_B_MODE] = 1'b1;
        end
        // Serial byte handling
        if (enabled & st.ctrl[`DDCM_B_MODE] & serialByteDone)
        begin
            if (manual)
            begin
                next_st.sbyte = serialByteIn;
                next_st.ctrl[`DDCM_B_V1F] = 1'b1;
            end
            else
            begin
                next_st.engineRead = 1'b1;
                next_st.engineByte = mem[ptrMasked];
                next_st.ptr = ptrNext;
            end
        end
        if (~enabled)
        begin
            next_st.ctrl[`DDCM_B_MODE] = 1'b0;
            next_st.vBitCnt = 4'h0;
            next_st.txBit = 1'b1;
        end
        // Read data
        next_st.rdata = 32'h0000_0000;
        if (hready & hsel & htrans[1] & ~hwrite)
        begin
            if (haddr[11:0] == `DDCM_ADDR_CTRL)
                next_st.rdata = {24'h00_0000, 1'b0, st.ctrl[6:0]};
            else if (haddr[11:0] == `DDCM_ADDR_PTR)
                next_st.rdata = {24'h00_0000, st.ptr};
            else if (haddr[11:0] == `DDCM_ADDR_XDAT)
                next_st.rdata = {24'h00_0000, st.xdat};
            else if (haddr[11:0] == `DDCM_ADDR_WIN && manual)
                next_st.rdata = {24'h00_0000, mem[ptrMasked]};
            else if (haddr[11:0] == `DDCM_ADDR_SCTL)
                next_st.rdata = {24'h00_0000, st.sctl};
            else if (haddr[11:0] == `DDCM_ADDR_SBYTE)
                next_st.rdata = {24'h00_0000, st.sbyte};
            else if (haddr[11:0] == `DDCM_ADDR_IRQ)
                next_st.rdata = {30'h0000_0000, st.ctrl[`DDCM_B_SWF], st.ctrl[`DDCM_B_V1F]};
            else if (haddr[11:0] == `DDCM_ADDR_MASK)
                next_st.rdata = {30'h0000_0000, st.irqMask};
            else if (haddr[11:0] == `DDCM_ADDR_SLAVE)
                next_st.rdata = {25'h000_0000, `DDCM_DDC2_ADDR};
        end
        // Interrupt and ownership, no interrupt while disabled
        next_st.irq = enabled & |({next_st.ctrl[`DDCM_B_SWF], next_st.ctrl[`DDCM_B_V1F]} & st.irqMask);
        next_st.cpuSel = manual & (cpuDataAddr >= `DDCM_WIN_BASE);
        next_st.extSel = ~enabled & ~manual & (cpuDataAddr >= `DDCM_WIN_BASE);
        next_st.addrMatch = serialAddrValid & match & enabled & st.sctl[`DDCM_B_I2CEN];
    end
    // =============================================
    // Registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.ctrl <= `DDCM_CTRL_RST;
            st.txBit <= 1'b1;
        end
        else
            st <= next_st;
        if (winWr)
            mem[ptrMasked] <= wb;
    end
    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpuBufSel = st.cpuSel;
    assign cpuExtSel = st.extSel;
    assign serialAddrMatch = st.addrMatch;
    assign engineByte = st.engineByte;
    assign engineRead = st.engineRead;
    assign sdaTxBit = st.txBit;
    assign irq = st.irq;
endmodule

// file: ddcm_checker.sv
`timescale 1ns/100ps
// ==========
// Port checks
module ddcm_checker
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] cpuDataAddr,
    input wire logic cpuBufSel,
    input wire logic cpuExtSel,
    input wire logic serialAddrMatch,
    input wire logic engineRead,
    input wire logic sdaTxBit,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_rel;
        $fell(srst);
    endsequence
    a_buf_window: assert property (cpuBufSel |-> $past(cpuDataAddr) >= 16'hFF00) else $error("buf sel");
    a_ext_window: assert property (cpuExtSel |-> $past(cpuDataAddr) >= 16'hFF00) else $error("ext sel");
    a_sel_apart: assert property (!(cpuBufSel && cpuExtSel)) else $error("both selects");
    a_reset_clear: assert property (s_rel |-> !irq && !cpuBufSel && !cpuExtSel && !engineRead) else $error("rst");
    a_rdata_reset: assert property (s_rel |-> hrdata == 32'h0000_0000) else $error("rdata rst");
    a_tx_idle: assert property (s_rel |-> sdaTxBit) else $error("tx idle");
    a_read_pulse: assert property (engineRead |=> !engineRead) else $error("fetch pulse");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus resp");
endmodule
bind ddc_slave_mode_control ddcm_checker u_chk (.clk, .srst, .hrdata, .hreadyout, .hresp, .cpuDataAddr,
    .cpuBufSel, .cpuExtSel, .serialAddrMatch, .engineRead, .sdaTxBit, .irq);

// file: ddcm_host_model.sv
`timescale 1ns/100ps
// ==========
// Display host side of the link
module ddcm_host_model
(
    input wire logic clk,
    output logic vsyncClk = 1'b0,
    output logic serialAddrValid = 1'b0,
    output logic [6:0] serialAddr = 7'h00,
    output logic serialByteDone = 1'b0,
    output logic [7:0] serialByteIn = 8'h00
);
    // Link clock runs only for the n pulses that each call asks for
    task automatic vsync(input int n);
        #1.3;
        repeat (n)
        begin
            #24 vsyncClk = 1'b1;
            #24 vsyncClk = 1'b0;
        end
    endtask
    task automatic send_addr(input logic [6:0] a);
        @(posedge clk);
        serialAddrValid <= 1'b1;
        serialAddr <= a;
        @(posedge clk);
        serialAddrValid <= 1'b0;
        serialAddr <= ~a;
    endtask
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        serialByteDone <= 1'b1;
        serialByteIn <= b;
        @(posedge clk);
        serialByteDone <= 1'b0;
        serialByteIn <= ~b;
    endtask
endmodule

// file: test_ddc_slave_mode_control.sv
`timescale 1ns/100ps
`include "ddcm_cfg.svh"
// ==========
// Bench
module test_ddc_slave_mode_control;
    logic clk = 0, srst = 1, hwrite = 0, hsel = 0, hready, hreadyout, hresp, vsyncClk, serialAddrValid;
    logic serialByteDone, cpuBufSel, cpuExtSel, serialAddrMatch, engineRead, sdaTxBit, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] cpuDataAddr = 0;
    logic [6:0] serialAddr;
    logic [7:0] serialByteIn, engineByte;
    int fails = 0, check_count = 0, n;
    localparam logic [11:0] CT = `DDCM_ADDR_CTRL;
    always #2.5 clk = ~clk;
    assign hready = hreadyout;
    ddc_slave_mode_control u_dut (.clk, .srst, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready,
        .hrdata, .hreadyout, .hresp, .vsyncClk, .serialAddrValid, .serialAddr, .serialByteDone, .serialByteIn,
        .cpuDataAddr, .cpuBufSel, .cpuExtSel, .serialAddrMatch, .engineByte, .engineRead, .sdaTxBit, .irq);
    ddcm_host_model u_host (.clk, .vsyncClk, .serialAddrValid, .serialAddr, .serialByteDone, .serialByteIn);
    task automatic results;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdy;
        n = 0;
        do
            @(posedge clk);
        while (hready !== 1'b1 && ++n < 20);
        if (hready !== 1'b1)
        begin
            $display("[FAIL] %0t bus timeout", $time);
            fails++;
            results();
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rc(CT, 32'h0000_0000);
        rc(12'h100, 32'h0000_0000);
        wr(CT, 32'h0000_00FF);
        rc(CT, 32'h0000_0074);
        $display("reset test done");
        for (int i = 1; i >= 0; i--)
        begin
            wr(CT, i ? 32'h0000_0060 : 32'h0000_0020);
            wr(`DDCM_ADDR_PTR, 32'h0000_007F);
            wr(`DDCM_ADDR_WIN, 32'h0000_0033);
            rc(`DDCM_ADDR_PTR, i ? 32'h0000_0080 : 32'h0000_0000);
        end
        wr(`DDCM_ADDR_WIN, 32'h0000_0044);
        cpuDataAddr <= 16'hFF10;
        repeat (2) @(negedge clk);
        chk(cpuBufSel, 1'b1);
        wr(CT, 32'h0000_0000);
        repeat (2) @(negedge clk);
        chk({cpuBufSel, cpuExtSel}, 2'b01);
        $display("buffer test done");
        wr(`DDCM_ADDR_PTR, 32'h0000_0000);
        wr(`DDCM_ADDR_MASK, 32'h0000_0003);
        wr(`DDCM_ADDR_SCTL, 32'h0000_0040);
        wr(CT, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chk({cpuBufSel, cpuExtSel}, 2'b00);
        fork
            begin
                u_host.send_addr(7'h50);
                u_host.send_byte(8'h5A);
            end
            for (n = 0; n < 40 && engineRead !== 1'b1; n++)
                @(negedge clk);
        join
        chk({engineRead, engineByte}, 9'h144);
        if (engineRead !== 1'b1)
            results();
        rc(CT, 32'h0000_0007);
        rc(`DDCM_ADDR_IRQ, 32'h0000_0002);
        chk(irq, 1'b1);
        wr(CT, 32'h0000_0004);
        rc(CT, 32'h0000_0005);
        chk(irq, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            wr(`DDCM_ADDR_SCTL, 32'h0000_0000);
            wr(CT, 32'h0000_0000);
            wr(CT, i ? 32'h0000_0014 : 32'h0000_0004);
            wr(`DDCM_ADDR_SCTL, 32'h0000_0040);
            fork
                u_host.send_addr(7'h53);
                begin
                    repeat (2) @(posedge clk);
                    @(negedge clk);
                    chk(serialAddrMatch, i);
                end
            join
            rc(CT, i ? 32'h0000_0017 : 32'h0000_0004);
        end
        $display("switch test done");
        wr(`DDCM_ADDR_SCTL, 32'h0000_0000);
        wr(CT, 32'h0000_0000);
        wr(CT, 32'h0000_0024);
        u_host.vsync(8);
        rc(CT, 32'h0000_0024);
        u_host.vsync(1);
        rc(CT, 32'h0000_002C);
        chk(irq, 1'b1);
        wr(`DDCM_ADDR_MASK, 32'h0000_0000);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        wr(CT, 32'h0000_0020);
        u_host.vsync(9);
        rc(CT, 32'h0000_0020);
        $display("vsync test done");
        results();
    end
endmodule
